// ===== chgreg_host_model.sv
// Two-wire bus master model standing in for the host processor
`timescale 1ns/100ps
`default_nettype none
module chgreg_host_model #(
  parameter int QTR = 4
) (
  input  wire logic       i_clk,
  input  wire logic       i_sda,
  output logic            o_scl,
  output logic            o_sda_oe,
  output logic            o_rd_valid,
  output logic      [7:0] o_rd_byte
);
  initial begin
    o_scl      = 1'b1;
    o_sda_oe   = 1'b0;
    o_rd_valid = 1'b0;
    o_rd_byte  = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask : tick
  // Data changes only while the clock is low
  task automatic put_bit(input logic b);
    o_sda_oe <= ~b;
    tick(QTR);
    o_scl <= 1'b1;
    tick(2 * QTR);
    o_scl <= 1'b0;
    tick(QTR);
  endtask : put_bit
  task automatic get_bit(output logic b);
    o_sda_oe <= 1'b0;
    tick(QTR);
    o_scl <= 1'b1;
    tick(QTR);
    b = i_sda;
    tick(QTR);
    o_scl <= 1'b0;
    tick(QTR);
  endtask : get_bit
  task automatic start_cond();
    o_scl <= 1'b1;
    tick(QTR);
    o_sda_oe <= 1'b1;
    tick(QTR);
    o_scl <= 1'b0;
    tick(QTR);
  endtask : start_cond
  task automatic stop_cond();
    o_sda_oe <= 1'b1;
    tick(QTR);
    o_scl <= 1'b1;
    tick(QTR);
    o_sda_oe <= 1'b0;
    tick(2 * QTR);
  endtask : stop_cond
  task automatic send_byte(input logic [7:0] b, output logic nack);
    for (int i = 7; i >= 0; i--) put_bit(b[i]);
    get_bit(nack);
  endtask : send_byte
  task automatic recv_byte(input logic last);
    logic [7:0] b;
    for (int i = 7; i >= 0; i--) get_bit(b[i]);
    o_rd_byte <= b;
    o_rd_valid <= 1'b1;
    tick(1);
    o_rd_valid <= 1'b0;
    put_bit(last);
  endtask : recv_byte
  task automatic write_reg(input logic [7:0] ofs, input logic [7:0] data, output logic nack);
    logic n0, n1, n2;
    start_cond();
    send_byte({chgreg_pkg::SLAVE_ADDR, 1'b0}, n0);
    send_byte(ofs, n1);
    send_byte(data, n2);
    stop_cond();
    nack = n0 | n1 | n2;
  endtask : write_reg
  task automatic read_regs(input logic [7:0] ofs, input int n);
    logic nk;
    start_cond();
    send_byte({chgreg_pkg::SLAVE_ADDR, 1'b0}, nk);
    send_byte(ofs, nk);
    stop_cond();
    start_cond();
    send_byte({chgreg_pkg::SLAVE_ADDR, 1'b1}, nk);
    for (int i = 0; i < n; i++) recv_byte(i == n - 1);
    stop_cond();
  endtask : read_regs
  task automatic probe(input logic [6:0] addr, output logic nack);
    start_cond();
    send_byte({addr, 1'b0}, nack);
    stop_cond();
  endtask : probe
endmodule : chgreg_host_model
`default_nettype wire

// ===== chgreg_pkg.sv
// Package: constants and types for the charger register bank
// How it works
// - Only the slave address 1001010 is acknowledged, with its direction bit after it.
// - A write carries register offset, then data stored at that offset.
// - Direction bit low means write, high means read.
// - Status pin drive: 00 automatic, 01 forced low, 10 released, 11 undefined.
// - Mode field: 00 off/high impedance, 01 boost, 10 charge, 11 charge with recharge.
// - Writing one to detection start launches it; cleared by the device when done.
// - Detection starts by itself after every reset.
// - While charging, detection outcome picks a 500mA or 1A input limit.
// - High impedance mode halts charging and boosting.
// - Source select zero applies the larger of host limit and detection result.
// - Source select one applies only the host limit code.
// - Charge current code maps 20mV plus 4mV per step, up to 80mV.
// - Termination code maps 1mV to 8mV in 1mV steps.
// - While charging, the lower of charge code and safety maximum applies.
// - Host limit code: 00 100mA, 01 500mA, 11 no limit.
// - Safety maximum code maps from 20mV upward and caps the charge code.
package chgreg_pkg;
  localparam logic [6:0] SLAVE_ADDR   = 7'h4a;
  localparam logic [7:0] OFS_ENABLE   = 8'h00;
  localparam logic [7:0] OFS_CURRENT  = 8'h01;
  localparam logic [7:0] OFS_VOLTAGE  = 8'h02;
  localparam logic [7:0] OFS_SPECIAL  = 8'h03;
  localparam logic [7:0] OFS_SAFETY   = 8'h04;
  localparam logic [7:0] OFS_STAT1    = 8'h06;
  localparam logic [7:0] OFS_STAT2    = 8'h07;
  localparam logic [7:0] OFS_EVGEN    = 8'h08;
  localparam logic [7:0] OFS_EVCHG    = 8'h09;
  localparam logic [7:0] OFS_EVBST    = 8'h0a;
  localparam logic [7:0] OFS_MSKGEN   = 8'h0b;
  localparam logic [7:0] OFS_MSKCHG   = 8'h0c;
  localparam logic [7:0] OFS_MSKBST   = 8'h0d;
  localparam logic [7:0] OFS_PARTID   = 8'h0e;
  localparam int         NUM_REGS     = 16;
  localparam logic [7:0] RST_ENABLE   = 8'h0a;
  localparam logic [7:0] RST_CURRENT  = 8'h01;
  localparam logic [7:0] RST_VOLTAGE  = 8'h19;
  localparam logic [7:0] RST_SPECIAL  = 8'h02;
  localparam logic [7:0] RST_SAFETY   = 8'h40;
  localparam logic [7:0] RST_STAT2    = 8'h01;
  localparam logic [7:0] RST_ZERO     = 8'h00;
  // Arbitrary neutral identification value
  localparam logic [7:0] PART_ID      = 8'h5a;
  // Field positions
  localparam int BIT_DETECT_GO  = 2;
  localparam int BIT_AUX_REG    = 3;
  localparam int BIT_LIMIT_SRC  = 7;
  localparam int MODE_LSB       = 0;
  localparam int STATPIN_LSB    = 6;
  localparam int CHG_CODE_LSB   = 3;
  localparam int TERM_CODE_LSB  = 0;
  localparam int MAX_CODE_LSB   = 4;
  localparam int HOST_LIM_LSB   = 6;
  // Sense voltages in mV
  localparam logic [6:0] CHG_BASE_MV  = 7'h14;
  localparam logic [6:0] CHG_STEP_MV  = 7'h04;
  localparam logic [3:0] TERM_BASE_MV = 4'h1;
  // Detection duration
  localparam int DETECT_TIME_US = 100;
  localparam int CLK_MHZ        = 20;
  localparam int DETECT_CYCLES  = DETECT_TIME_US * CLK_MHZ;

  typedef enum logic [1:0] {
    CHGREG_MODE_OFF, CHGREG_MODE_BOOST, CHGREG_MODE_CHARGE, CHGREG_MODE_RECHARGE
  } chgreg_mode_type;

  typedef enum logic [1:0] {
    CHGREG_LIM_100, CHGREG_LIM_500, CHGREG_LIM_1000, CHGREG_LIM_NONE
  } chgreg_limit_type;

  typedef enum logic [1:0] {
    CHGREG_PIN_AUTO, CHGREG_PIN_LOW, CHGREG_PIN_HIGHZ, CHGREG_PIN_UNDEF
  } chgreg_statpin_type;

  typedef struct packed {
    logic               charge_on;
    logic               boost_on;
    logic               recharge_on;
    logic               high_impedance_mode;
    logic               aux_regulator_on;
    chgreg_statpin_type status_pin_drive;
    chgreg_limit_type   input_limit;
    logic [6:0]         charge_sense_mv;
    logic [3:0]         term_sense_mv;
  } chgreg_ctrl_type;
endpackage : chgreg_pkg

// ===== chgreg_props.sv
// Concurrent checks on the charger register bank ports
`timescale 1ns/100ps
`default_nettype none
module chgreg_props #(
  parameter int DETECT_CYCLES = 8
) (
  input wire logic                        i_clk,
  input wire logic                        i_rst_n,
  input wire logic                        i_scl,
  input wire logic                        i_sda,
  input wire logic                        o_sda_oe,
  input wire logic                        o_sda,
  input wire logic                        i_detect_is_wall,
  input wire logic [3:0]                  i_status_code,
  input wire logic                        o_detect_active,
  input wire logic                        o_status_pin_low,
  input wire chgreg_pkg::chgreg_ctrl_type o_ctrl
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  logic [15:0] det_cnt;
  // Length of the current detection run
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !o_detect_active) begin
      det_cnt <= 16'h0000;
    end else begin
      det_cnt <= det_cnt + 16'h0001;
    end
  end
  sequence settled_s;
    $past(i_rst_n) && $past(i_rst_n, 2);
  endsequence
  sequence charging_s;
    settled_s ##0 o_ctrl.charge_on;
  endsequence
  sequence pin_held_s(chgreg_pkg::chgreg_statpin_type drv);
    (o_ctrl.status_pin_drive == drv) [*3];
  endsequence
  sequence auto_busy_s;
    (o_ctrl.status_pin_drive == chgreg_pkg::CHGREG_PIN_AUTO && i_status_code != 4'h0) [*4];
  endsequence
  sda_level_a: assert property (o_sda_oe |-> !o_sda)
    else $error("device drives a high level on the data line");
  ack_stable_a: assert property (i_scl && $past(i_scl) && $past(i_scl, 2) |->
    $stable(o_sda_oe)) else $error("data line drive changed while clock high");
  mode_onehot_a: assert property (settled_s |->
    $onehot({o_ctrl.charge_on, o_ctrl.boost_on, o_ctrl.high_impedance_mode}))
    else $error("operating mode outputs not exclusive");
  recharge_mode_a: assert property (o_ctrl.recharge_on |-> o_ctrl.charge_on)
    else $error("recharge without charge");
  hiz_halt_a: assert property (o_ctrl.high_impedance_mode |->
    !o_ctrl.charge_on && !o_ctrl.boost_on) else $error("high impedance mode still active");
  pin_low_a: assert property (pin_held_s(chgreg_pkg::CHGREG_PIN_LOW) |-> o_status_pin_low)
    else $error("forced low status pin not low");
  pin_release_a: assert property (pin_held_s(chgreg_pkg::CHGREG_PIN_HIGHZ) |->
    !o_status_pin_low) else $error("released status pin driven low");
  pin_auto_a: assert property (auto_busy_s |-> o_status_pin_low)
    else $error("automatic status pin ignores charger state");
  detect_start_a: assert property ($rose(i_rst_n) |-> ##[1:3] o_detect_active)
    else $error("detection did not start after reset");
  detect_max_a: assert property (det_cnt <= DETECT_CYCLES + 2)
    else $error("detection runs too long");
  detect_min_a: assert property ($fell(o_detect_active) |-> det_cnt >= DETECT_CYCLES - 1)
    else $error("detection ended too early");
  charge_range_a: assert property (charging_s |->
    o_ctrl.charge_sense_mv inside {[7'h14:7'h50]} && o_ctrl.charge_sense_mv[1:0] == 2'h0)
    else $error("charge sense voltage off the step grid");
  term_range_a: assert property (charging_s |-> o_ctrl.term_sense_mv inside {[4'h1:4'h8]})
    else $error("termination sense voltage out of range");
endmodule : chgreg_props
bind chgreg_top chgreg_props #(.DETECT_CYCLES(DETECT_CYCLES)) u_chgreg_props (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_scl(i_scl), .i_sda(i_sda), .o_sda_oe(o_sda_oe),
  .o_sda(o_sda), .i_detect_is_wall(i_detect_is_wall), .i_status_code(i_status_code),
  .o_detect_active(o_detect_active), .o_status_pin_low(o_status_pin_low), .o_ctrl(o_ctrl));
`default_nettype wire

// ===== chgreg_regfile.sv
// Small register memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module chgreg_regfile #(
  parameter int DEPTH = 16
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_n,
  input  wire logic                       i_we,
  input  wire logic [$clog2(DEPTH)-1:0]   i_waddr,
  input  wire logic [7:0]                 i_wdata,
  input  wire logic [$clog2(DEPTH)-1:0]   i_raddr,
  output logic      [7:0]                 o_rdata,
  output logic      [DEPTH*8-1:0]         o_all
);
  logic [7:0] mem [DEPTH];

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_cell
      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          mem[g] <= chgreg_pkg::RST_ZERO;
        end else if (i_we && i_waddr == ($clog2(DEPTH))'(g)) begin
          mem[g] <= i_wdata;
        end
      end
      assign o_all[g*8 +: 8] = mem[g];
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata <= chgreg_pkg::RST_ZERO;
    end else begin
      o_rdata <= mem[i_raddr];
    end
  end
endmodule : chgreg_regfile
`default_nettype wire

// ===== chgreg_top.sv
// Charger register bank behind a two-wire serial slave
`timescale 1ns/100ps
`default_nettype none
module chgreg_top #(
  parameter int DETECT_CYCLES = chgreg_pkg::DETECT_CYCLES
) (
  input  wire logic                        i_clk,
  input  wire logic                        i_rst_n,
  input  wire logic                        i_scl,
  input  wire logic                        i_sda,
  output logic                             o_sda_oe,
  output logic                             o_sda,
  input  wire logic                        i_detect_is_wall,
  input  wire logic [3:0]                  i_status_code,
  output logic                             o_detect_active,
  output logic                             o_status_pin_low,
  output chgreg_pkg::chgreg_ctrl_type      o_ctrl
);
  typedef enum logic [2:0] {
    CHGREG_ST_IDLE, CHGREG_ST_ADDR, CHGREG_ST_OFS, CHGREG_ST_WDATA, CHGREG_ST_RDATA,
    CHGREG_ST_ACK, CHGREG_ST_RACK, CHGREG_ST_SKIP
  } chgreg_state_type;

  chgreg_state_type state;
  chgreg_state_type after_ack;
  logic [1:0]       scl_d;
  logic [1:0]       sda_d;
  logic             start_seen;
  logic             stop_seen;
  logic             scl_rise;
  logic             scl_fall;
  logic [3:0]       bit_cnt;
  logic [7:0]       shift;
  logic [7:0]       offset;
  logic [7:0]       enable_control;
  logic             detect_busy;
  logic             detect_wall;
  logic [31:0]      detect_cnt;
  logic             reset_detect_pending;
  logic             wr_hit;
  logic [7:0]       wr_data;
  logic             rf_we;
  logic [7:0]       rf_rdata;
  logic [127:0]     rf_all;
  logic [7:0]       read_byte;
  logic [7:0]       next_ctrl_byte;

  // Bus lines are taken as synchronous; edges found from one-cycle history
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      scl_d <= 2'h3;
      sda_d <= 2'h3;
    end else begin
      scl_d <= {scl_d[0], i_scl};
      sda_d <= {sda_d[0], i_sda};
    end
  end

  assign scl_rise   = !scl_d[1] && scl_d[0];
  assign scl_fall   = scl_d[1] && !scl_d[0];
  assign start_seen = scl_d[0] && scl_d[1] && sda_d[1] && !sda_d[0];
  assign stop_seen  = scl_d[0] && scl_d[1] && !sda_d[1] && sda_d[0];

  function automatic logic is_writable(input logic [7:0] ofs);
    is_writable = (ofs <= chgreg_pkg::OFS_SAFETY) ||
                  (ofs >= chgreg_pkg::OFS_MSKGEN && ofs <= chgreg_pkg::OFS_MSKBST);
  endfunction : is_writable

  // Serial slave state machine
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state     <= CHGREG_ST_IDLE;
      after_ack <= CHGREG_ST_IDLE;
      bit_cnt   <= 4'h0;
      shift     <= 8'h00;
      offset    <= 8'h00;
      wr_hit    <= 1'b0;
      wr_data   <= 8'h00;
      o_sda_oe  <= 1'b0;
      o_sda     <= 1'b0;
    end else begin
      wr_hit <= 1'b0;
      if (start_seen) begin
        state    <= CHGREG_ST_ADDR;
        bit_cnt  <= 4'h0;
        o_sda_oe <= 1'b0;
      end else if (stop_seen) begin
        state    <= CHGREG_ST_IDLE;
        o_sda_oe <= 1'b0;
      end else begin
        unique case (state)
          CHGREG_ST_IDLE, CHGREG_ST_SKIP: begin
            o_sda_oe <= 1'b0;
          end
          CHGREG_ST_ADDR, CHGREG_ST_OFS, CHGREG_ST_WDATA: begin
            if (scl_rise) begin
              shift   <= {shift[6:0], sda_d[0]};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              bit_cnt <= 4'h0;
              if (state == CHGREG_ST_ADDR) begin
                if (shift[7:1] == chgreg_pkg::SLAVE_ADDR) begin
                  o_sda_oe  <= 1'b1;
                  after_ack <= shift[0] ? CHGREG_ST_RDATA : CHGREG_ST_OFS;
                  state     <= CHGREG_ST_ACK;
                end else begin
                  state <= CHGREG_ST_SKIP;
                end
              end else if (state == CHGREG_ST_OFS) begin
                offset    <= shift;
                o_sda_oe  <= 1'b1;
                after_ack <= CHGREG_ST_WDATA;
                state     <= CHGREG_ST_ACK;
              end else begin
                wr_hit    <= is_writable(offset);
                wr_data   <= shift;
                o_sda_oe  <= 1'b1;
                after_ack <= CHGREG_ST_WDATA;
                state     <= CHGREG_ST_ACK;
              end
            end
          end
          CHGREG_ST_ACK: begin
            if (scl_fall) begin
              state <= after_ack;
              if (after_ack == CHGREG_ST_RDATA) begin
                shift    <= read_byte;
                o_sda_oe <= !read_byte[7];
                bit_cnt  <= 4'h1;
              end else begin
                o_sda_oe <= 1'b0;
              end
              if (after_ack == CHGREG_ST_WDATA && offset != 8'h00 && bit_cnt == 4'h0) begin
                offset <= offset;
              end
            end
          end
          CHGREG_ST_RDATA: begin
            if (scl_fall) begin
              if (bit_cnt == 4'h8) begin
                o_sda_oe <= 1'b0;
                bit_cnt  <= 4'h0;
                offset   <= offset + 8'h01;
                state    <= CHGREG_ST_RACK;
              end else begin
                shift    <= {shift[6:0], 1'b0};
                o_sda_oe <= !shift[6];
                bit_cnt  <= bit_cnt + 4'h1;
              end
            end
          end
          CHGREG_ST_RACK: begin
            if (scl_rise) begin
              state <= sda_d[0] ? CHGREG_ST_SKIP : CHGREG_ST_ACK;
              after_ack <= CHGREG_ST_RDATA;
            end
          end
          default: state <= CHGREG_ST_IDLE;
        endcase
      end
    end
  end

  // Write data leaves the offset unchanged after each stored byte; only reads advance it
  logic wr_hit_d;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wr_hit_d <= 1'b0;
    end else begin
      wr_hit_d <= wr_hit;
    end
  end

  assign rf_we = wr_hit && offset != chgreg_pkg::OFS_ENABLE;

  chgreg_regfile #(.DEPTH(chgreg_pkg::NUM_REGS)) u_regs (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_we    (rf_we),
    .i_waddr (offset[3:0]),
    .i_wdata (wr_data),
    .i_raddr (offset[3:0]),
    .o_rdata (rf_rdata),
    .o_all   (rf_all)
  );

  // Reset values for the configuration registers held in the memory
  logic [7:0] cfg_current;
  logic [7:0] cfg_voltage;
  logic [7:0] cfg_safety;
  logic       cfg_touched_cur;
  logic       cfg_touched_vol;
  logic       cfg_touched_saf;
  logic       cfg_touched_spc;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cfg_touched_cur <= 1'b0;
      cfg_touched_vol <= 1'b0;
      cfg_touched_saf <= 1'b0;
      cfg_touched_spc <= 1'b0;
    end else if (rf_we) begin
      if (offset == chgreg_pkg::OFS_CURRENT) cfg_touched_cur <= 1'b1;
      if (offset == chgreg_pkg::OFS_VOLTAGE) cfg_touched_vol <= 1'b1;
      if (offset == chgreg_pkg::OFS_SAFETY)  cfg_touched_saf <= 1'b1;
      if (offset == chgreg_pkg::OFS_SPECIAL) cfg_touched_spc <= 1'b1;
    end
  end

  function automatic logic [7:0] reg_at(input logic [7:0] ofs);
    reg_at = rf_all[ofs[3:0]*8 +: 8];
  endfunction : reg_at

  // Procedural so memory updates inside reg_at are followed
  always_comb begin
    cfg_current = cfg_touched_cur ? reg_at(chgreg_pkg::OFS_CURRENT) : chgreg_pkg::RST_CURRENT;
    cfg_voltage = cfg_touched_vol ? reg_at(chgreg_pkg::OFS_VOLTAGE) : chgreg_pkg::RST_VOLTAGE;
    cfg_safety  = cfg_touched_saf ? reg_at(chgreg_pkg::OFS_SAFETY)  : chgreg_pkg::RST_SAFETY;
  end

  // Read multiplexer
  always_comb begin
    unique case (offset)
      chgreg_pkg::OFS_ENABLE:  read_byte = enable_control;
      chgreg_pkg::OFS_CURRENT: read_byte = cfg_current;
      chgreg_pkg::OFS_VOLTAGE: read_byte = cfg_voltage;
      chgreg_pkg::OFS_SPECIAL: read_byte = cfg_touched_spc ? reg_at(offset) : chgreg_pkg::RST_SPECIAL;
      chgreg_pkg::OFS_SAFETY:  read_byte = cfg_safety;
      chgreg_pkg::OFS_STAT1:   read_byte = {3'h0, i_status_code, 1'b0};
      chgreg_pkg::OFS_STAT2:   read_byte = chgreg_pkg::RST_STAT2;
      chgreg_pkg::OFS_MSKGEN, chgreg_pkg::OFS_MSKCHG, chgreg_pkg::OFS_MSKBST:
                               read_byte = reg_at(offset);
      chgreg_pkg::OFS_PARTID:  read_byte = chgreg_pkg::PART_ID;
      default:                 read_byte = chgreg_pkg::RST_ZERO;
    endcase
  end

  // Enable register; detection start bit cleared when detection ends
  always_comb begin
    next_ctrl_byte = enable_control;
    if (wr_hit && offset == chgreg_pkg::OFS_ENABLE) begin
      next_ctrl_byte = wr_data;
    end
    if (detect_busy && detect_cnt == 32'h0 && !(wr_hit && offset == chgreg_pkg::OFS_ENABLE
        && wr_data[chgreg_pkg::BIT_DETECT_GO])) begin
      next_ctrl_byte[chgreg_pkg::BIT_DETECT_GO] = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      enable_control <= chgreg_pkg::RST_ENABLE;
    end else begin
      enable_control <= next_ctrl_byte;
    end
  end

  // Charger detection sequencer
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      reset_detect_pending <= 1'b1;
      detect_busy          <= 1'b0;
      detect_cnt           <= 32'h0;
      detect_wall          <= 1'b0;
    end else begin
      reset_detect_pending <= 1'b0;
      if (!detect_busy && (reset_detect_pending ||
          enable_control[chgreg_pkg::BIT_DETECT_GO])) begin
        detect_busy <= 1'b1;
        detect_cnt  <= 32'(DETECT_CYCLES - 1);
      end else if (detect_busy) begin
        if (detect_cnt == 32'h0) begin
          detect_busy <= 1'b0;
          detect_wall <= i_detect_is_wall;
        end else begin
          detect_cnt <= detect_cnt - 32'h1;
        end
      end
    end
  end

  // Control outputs
  chgreg_pkg::chgreg_mode_type mode;
  logic [3:0] chg_code;
  logic [3:0] max_code;
  logic [3:0] eff_code;
  logic [1:0] host_lim;
  logic [1:0] det_lim;
  assign mode     = chgreg_pkg::chgreg_mode_type'(enable_control[chgreg_pkg::MODE_LSB +: 2]);
  assign chg_code = cfg_current[chgreg_pkg::CHG_CODE_LSB +: 4];
  assign max_code = cfg_safety[chgreg_pkg::MAX_CODE_LSB +: 4];
  assign eff_code = (chg_code < max_code) ? chg_code : max_code;
  assign host_lim = cfg_voltage[chgreg_pkg::HOST_LIM_LSB +: 2];
  assign det_lim  = detect_wall ? 2'(chgreg_pkg::CHGREG_LIM_1000)
                                : 2'(chgreg_pkg::CHGREG_LIM_500);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_ctrl           <= '0;
      o_detect_active  <= 1'b0;
      o_status_pin_low <= 1'b0;
    end else begin
      o_ctrl.charge_on    <= mode == chgreg_pkg::CHGREG_MODE_CHARGE ||
                             mode == chgreg_pkg::CHGREG_MODE_RECHARGE;
      o_ctrl.boost_on     <= mode == chgreg_pkg::CHGREG_MODE_BOOST;
      o_ctrl.recharge_on  <= mode == chgreg_pkg::CHGREG_MODE_RECHARGE;
      o_ctrl.high_impedance_mode <= mode == chgreg_pkg::CHGREG_MODE_OFF;
      o_ctrl.aux_regulator_on    <= enable_control[chgreg_pkg::BIT_AUX_REG];
      o_ctrl.status_pin_drive    <=
        chgreg_pkg::chgreg_statpin_type'(enable_control[chgreg_pkg::STATPIN_LSB +: 2]);
      if (cfg_current[chgreg_pkg::BIT_LIMIT_SRC]) begin
        o_ctrl.input_limit <= chgreg_pkg::chgreg_limit_type'(host_lim);
      end else begin
        o_ctrl.input_limit <= chgreg_pkg::chgreg_limit_type'(
          (host_lim > det_lim) ? host_lim : det_lim);
      end
      o_ctrl.charge_sense_mv <= chgreg_pkg::CHG_BASE_MV +
        7'(eff_code) * chgreg_pkg::CHG_STEP_MV;
      o_ctrl.term_sense_mv <= chgreg_pkg::TERM_BASE_MV +
        4'(cfg_current[chgreg_pkg::TERM_CODE_LSB +: 3]);
      o_detect_active <= detect_busy;
      unique case (enable_control[chgreg_pkg::STATPIN_LSB +: 2])
        2'h0:    o_status_pin_low <= i_status_code != 4'h0;
        2'h1:    o_status_pin_low <= 1'b1;
        default: o_status_pin_low <= 1'b0;
      endcase
    end
  end
endmodule : chgreg_top
`default_nettype wire

// ===== test_chgreg_top.sv
// Self-checking bench for the charger register bank
`timescale 1ns/100ps
`default_nettype none
module test_chgreg_top;
  logic                        clk = 1'b0;
  logic                        rst_n = 1'b0;
  logic                        scl, host_oe, dut_oe, dut_sda, rd_valid, detect_active, pin_low;
  logic [7:0]                  rd_byte;
  logic                        detect_is_wall = 1'b1;
  logic [3:0]                  status_code = 4'h0;
  chgreg_pkg::chgreg_ctrl_type ctrl;
  wire logic                   sda_line;
  int                          n_mismatch = 0;
  int                          n_compared = 0;
  int                          cycles = 0;
  int                          seed = 24;
  logic [7:0]                  exp_q[$];
  logic                        nack;
  // Open-drain wire with pull-up
  assign sda_line = ~(host_oe | (dut_oe & ~dut_sda));
  always #25 clk = ~clk;
  chgreg_top #(.DETECT_CYCLES(8)) u_chgreg_top (.i_clk(clk), .i_rst_n(rst_n), .i_scl(scl),
    .i_sda(sda_line), .o_sda_oe(dut_oe), .o_sda(dut_sda), .i_detect_is_wall(detect_is_wall),
    .i_status_code(status_code), .o_detect_active(detect_active), .o_status_pin_low(pin_low),
    .o_ctrl(ctrl));
  chgreg_host_model u_chgreg_host_model (.i_clk(clk), .i_sda(sda_line), .o_scl(scl),
    .o_sda_oe(host_oe), .o_rd_valid(rd_valid), .o_rd_byte(rd_byte));
  task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
    n_compared++;
    if (seen !== want) begin
      n_mismatch++;
      $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, want);
    end
  endtask : check
  task automatic end_of_test();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test
  always @(posedge clk) begin
    if (rd_valid === 1'b1) begin
      check(rd_byte, exp_q.pop_front(), "read data");
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial begin : main
    logic [7:0] v;
    logic [3:0] chg, mx, mn;
    logic [1:0] lim;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    check({7'h0, detect_active}, 8'h01, "auto detection");
    repeat (20) @(posedge clk);
    check({6'h0, ctrl.input_limit}, 8'h02, "wall limit");
    exp_q = {8'h0a, 8'h01, 8'h19, 8'h02, 8'h40, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00,
             8'h00, 8'h00, 8'h00, 8'h00, chgreg_pkg::PART_ID};
    u_chgreg_host_model.read_regs(8'h00, 15);
    for (int p = 0; p < 3; p++) begin
      for (int m = 0; m < 4; m++) begin
        v = $random(seed);
        status_code <= v[7:4];
        u_chgreg_host_model.write_reg(8'h00, {p[1:0], 2'h0, v[0], 1'b0, m[1:0]}, nack);
        repeat (4) @(posedge clk);
        check({7'h0, nack}, 8'h00, "ack");
        check({7'h0, ctrl.charge_on}, {7'h0, m[1]}, "charge");
        check({7'h0, ctrl.boost_on}, {7'h0, m == 1}, "boost");
        check({7'h0, ctrl.recharge_on}, {7'h0, m == 3}, "recharge");
        check({7'h0, ctrl.high_impedance_mode}, {7'h0, m == 0}, "hiz");
        check({7'h0, ctrl.aux_regulator_on}, {7'h0, v[0]}, "aux");
        check({6'h0, ctrl.status_pin_drive}, {6'h0, p[1:0]}, "pin field");
        check({7'h0, pin_low}, {7'h0, p == 1 || (p == 0 && v[7:4] != 4'h0)}, "pin");
      end
    end
    detect_is_wall <= 1'b0;
    u_chgreg_host_model.write_reg(8'h00, 8'h0e, nack);
    repeat (30) @(posedge clk);
    check({6'h0, ctrl.input_limit}, 8'h01, "usb limit");
    exp_q.push_back(8'h0a);
    u_chgreg_host_model.read_regs(8'h00, 1);
    for (int s = 0; s < 2; s++) begin
      for (int h = 0; h < 4; h++) begin
        u_chgreg_host_model.write_reg(8'h02, {h[1:0], 6'h19}, nack);
        u_chgreg_host_model.write_reg(8'h01, {s[0], 7'h01}, nack);
        repeat (4) @(posedge clk);
        lim = (s == 1 || h > 1) ? h[1:0] : 2'h1;
        check({6'h0, ctrl.input_limit}, {6'h0, lim}, "input limit");
      end
    end
    for (int k = 0; k < 6; k++) begin
      v = $random(seed);
      chg = (k == 0) ? 4'hf : (k == 1) ? 4'h0 : v[3:0];
      mx = (k == 2) ? 4'h0 : (k < 2) ? 4'hf : v[7:4];
      mn = (chg < mx) ? chg : mx;
      u_chgreg_host_model.write_reg(8'h04, {mx, 4'h0}, nack);
      u_chgreg_host_model.write_reg(8'h01, {1'b0, chg, v[6:4]}, nack);
      repeat (4) @(posedge clk);
      check({1'b0, ctrl.charge_sense_mv}, 8'h14 + {2'h0, mn, 2'h0}, "chg");
      check({4'h0, ctrl.term_sense_mv}, {4'h0, 4'h1 + {1'b0, v[6:4]}}, "term");
    end
    u_chgreg_host_model.write_reg(8'h05, 8'hff, nack);
    u_chgreg_host_model.write_reg(chgreg_pkg::OFS_PARTID, 8'h00, nack);
    exp_q.push_back(8'h00);
    u_chgreg_host_model.read_regs(8'h05, 1);
    exp_q.push_back(chgreg_pkg::PART_ID);
    u_chgreg_host_model.read_regs(chgreg_pkg::OFS_PARTID, 1);
    u_chgreg_host_model.probe(7'h4b, nack);
    check({7'h0, nack}, 8'h01, "foreign address");
    repeat (4) @(posedge clk);
    end_of_test();
  end
endmodule : test_chgreg_top
`default_nettype wire
